// ==== hdl/lacs_consts.svh ====
/*
 * Constants of the load-adaptive current regulator and its serial config port:
 * command length, threshold scaling, step and decrement tables, reset values.
 * Assumes nothing; included by the package only, the design modules use its macros.
 */
`ifndef LACS_CONSTS_SVH
`define LACS_CONSTS_SVH

// serial command length in bits
`define LACS_CMD_BITS      20
`define LACS_CMD_MSB       19
`define LACS_SHIFT_RST     20'h00000
`define LACS_CMD_RST       20'h00000

// thresholds are codes times 32
`define LACS_THR_SHIFT     5
// coil values are scaled by (factor + 1) / 32
`define LACS_SCALE_SHIFT   5

// applied factor resets to the top code and is clamped into range at once
`define LACS_SE_RST        5'h1f
`define LACS_DN_CNT_RST    6'h00

// increment step per code 0..3
`define LACS_UP_STEP_0     6'h01
`define LACS_UP_STEP_1     6'h02
`define LACS_UP_STEP_2     6'h04
`define LACS_UP_STEP_3     6'h08

// measurements at or above the upper threshold per decrement, code 0..3
`define LACS_DN_NEED_0     6'h20
`define LACS_DN_NEED_1     6'h08
`define LACS_DN_NEED_2     6'h02
`define LACS_DN_NEED_3     6'h01

// filter averages 2**2 measurements
`define LACS_AVG_LOG2      2
`define LACS_AVG_CNT_LAST  2'h3
`define LACS_ACC_RST       12'h000

`endif

// ==== hdl/lacs_load_avg.sv ====
/*
 * Load measurement filter: passes each measurement through, or averages
 * four consecutive ones when enabled. Assumes one valid pulse per full step.
 */
`timescale 1ns/1ps

module lacs_load_avg (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       filt_en_i,
	input  wire logic [9:0] load_i,
	input  wire logic       load_valid_i,
	output logic      [9:0] avg_o,
	output logic            avg_valid_o
);
	import lacs_pkg::*;

	lacs_avg_st_t st_r;
	lacs_avg_st_t st_nxt;
	logic [11:0]  sum;

	always_comb begin
		st_nxt     = st_r;
		st_nxt.vld = 1'b0;
		sum        = st_r.acc + {2'h0, load_i};
		if (!filt_en_i) begin
			st_nxt.acc = `LACS_ACC_RST;
			st_nxt.cnt = 2'h0;
			if (load_valid_i) begin
				st_nxt.avg = load_i;
				st_nxt.vld = 1'b1;
			end
		end else if (load_valid_i) begin
			if (st_r.cnt == `LACS_AVG_CNT_LAST) begin
				st_nxt.avg = sum[11:`LACS_AVG_LOG2];
				st_nxt.vld = 1'b1;
				st_nxt.acc = `LACS_ACC_RST;
				st_nxt.cnt = 2'h0;
			end else begin
				st_nxt.acc = sum;
				st_nxt.cnt = st_r.cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '{acc: `LACS_ACC_RST, cnt: 2'h0, avg: 10'h000, vld: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avg_o       = st_r.avg;
	assign avg_valid_o = st_r.vld;

endmodule : lacs_load_avg

// ==== hdl/lacs_pkg.sv ====
/*
 * Types of the load-adaptive current regulator: configuration bundle,
 * and the state records of the top module, the synchroniser and the filter.
 * Assumes lacs_consts.svh is on the include path.
 */
`include "lacs_consts.svh"

package lacs_pkg;

	// regulator configuration, delivered as plain ports
	typedef struct packed {
		logic [4:0] current_scale;
		logic [1:0] increment_step_code;
		logic [1:0] decrement_rate_code;
		logic       minimum_current_limit_bit;
		logic [3:0] lower_load_threshold_code;
		logic [3:0] upper_load_window_code;
		logic       load_filter_enable;
	} lacs_cfg_t;

	typedef struct packed {
		logic                         sck_q;
		logic                         csn_q;
		logic [`LACS_CMD_BITS-1:0]    shift;
		logic                         sdo;
		logic [`LACS_CMD_BITS-1:0]    cmd;
		logic                         cmd_stb;
		logic [4:0]                   se;
		logic [5:0]                   dn_cnt;
		logic [7:0]                   coil_a;
		logic [7:0]                   coil_b;
	} lacs_top_st_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} lacs_sync_st_t;

	typedef struct packed {
		logic [11:0] acc;
		logic [1:0]  cnt;
		logic [9:0]  avg;
		logic        vld;
	} lacs_avg_st_t;

endpackage : lacs_pkg

// ==== hdl/lacs_sync.sv ====
/*
 * Three-flop input synchroniser with agreement filter for one pin.
 * Assumes the pin is asynchronous to clk_i; output is a clean level.
 */
`timescale 1ns/1ps

module lacs_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic d_i,
	output logic      q_o
);
	import lacs_pkg::*;

	lacs_sync_st_t st_r;
	lacs_sync_st_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// second and third stage agree: the change counts
		if (st_r.s2 == st_r.s3) begin
			st_nxt.q = st_r.s3;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_o = st_r.q;

endmodule : lacs_sync

// ==== hdl/lacs_top.sv ====
/*
 * Load-adaptive coil current regulator with its 20-bit serial config port.
 * Assumes the serial pins are asynchronous to clk_i and the bus clock runs
 * well below half the system clock; configuration arrives as plain ports.
 */
`timescale 1ns/1ps

module lacs_top (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// serial port pins
	input  wire logic                  sck_i,
	input  wire logic                  sdi_i,
	input  wire logic                  csn_i,
	output logic                       sdo_o,
	// received command
	output logic [`LACS_CMD_BITS-1:0]  cmd_word_o,
	output logic                       cmd_stb_o,
	// regulator configuration and load input
	input  wire lacs_pkg::lacs_cfg_t   cfg_i,
	input  wire logic [9:0]            load_measurement_i,
	input  wire logic                  load_valid_i,
	// coil currents before and after scaling
	input  wire logic [7:0]            coil_a_i,
	input  wire logic [7:0]            coil_b_i,
	output logic      [7:0]            coil_a_scaled_o,
	output logic      [7:0]            coil_b_scaled_o,
	output logic      [4:0]            applied_current_factor_o
);
	import lacs_pkg::*;

	lacs_top_st_t st_r;
	lacs_top_st_t st_nxt;

	logic       sck_s;
	logic       sdi_s;
	logic       csn_s;
	logic [9:0] filt_load;
	logic       filt_valid;

	// pin synchronisers
	// a select change closer than two clocks to a bus clock edge may be seen
	// in either order, so the host keeps them apart
	lacs_sync #(
		.RST_VAL (1'b1)
	) u_sync_sck (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (sck_i),
		.q_o     (sck_s)
	);

	lacs_sync #(
		.RST_VAL (1'b0)
	) u_sync_sdi (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (sdi_i),
		.q_o     (sdi_s)
	);

	lacs_sync #(
		.RST_VAL (1'b1)
	) u_sync_csn (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (csn_i),
		.q_o     (csn_s)
	);

	lacs_load_avg u_load_avg (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.filt_en_i    (cfg_i.load_filter_enable),
		.load_i       (load_measurement_i),
		.load_valid_i (load_valid_i),
		.avg_o        (filt_load),
		.avg_valid_o  (filt_valid)
	);

	// edges of the clean pin levels
	logic sck_rise;
	logic sck_fall;
	logic csn_rise;

	always_comb begin
		sck_rise = sck_s & ~st_r.sck_q;
		sck_fall = ~sck_s & st_r.sck_q;
		csn_rise = csn_s & ~st_r.csn_q;
	end

	// regulator thresholds and limits
	logic [9:0] thr_lo;
	logic [9:0] thr_hi;
	logic [4:0] thr_hi_code;
	logic [5:0] cs_plus1;
	logic [5:0] min_plus1;
	logic [4:0] se_min;
	logic [4:0] se_max;
	logic [5:0] up_step;
	logic [5:0] dn_need;

	// thresholds are whole multiples of 32 on the load scale
	always_comb begin
		thr_lo      = 10'h000;
		thr_hi      = 10'h000;
		thr_lo[9:`LACS_THR_SHIFT] = {1'b0, cfg_i.lower_load_threshold_code};
		thr_hi_code = {1'b0, cfg_i.lower_load_threshold_code}
		            + {1'b0, cfg_i.upper_load_window_code}
		            + 5'h01;
		thr_hi[9:`LACS_THR_SHIFT] = thr_hi_code;
	end

	// limits of the applied factor, recomputed whenever the scale moves
	always_comb begin
		// upper limit is the scale code
		se_max   = cfg_i.current_scale;
		cs_plus1 = {1'b0, cfg_i.current_scale} + 6'h01;
		// quarter when set, half when clear
		if (cfg_i.minimum_current_limit_bit) begin
			min_plus1 = cs_plus1 >> 2;
		end else begin
			min_plus1 = cs_plus1 >> 1;
		end
		// a fraction below 1/32 is held at the smallest code
		if (min_plus1 == 6'h00) begin
			se_min = 5'h00;
		end else begin
			se_min = 5'(min_plus1 - 6'h01);
		end
	end

	always_comb begin
		unique case (cfg_i.increment_step_code)
			2'h0: up_step = `LACS_UP_STEP_0;
			2'h1: up_step = `LACS_UP_STEP_1;
			2'h2: up_step = `LACS_UP_STEP_2;
			2'h3: up_step = `LACS_UP_STEP_3;
		endcase
	end

	always_comb begin
		unique case (cfg_i.decrement_rate_code)
			2'h0: dn_need = `LACS_DN_NEED_0;
			2'h1: dn_need = `LACS_DN_NEED_1;
			2'h2: dn_need = `LACS_DN_NEED_2;
			2'h3: dn_need = `LACS_DN_NEED_3;
		endcase
	end

	// coil scaling products, (factor + 1) never exceeds 32
	logic [5:0]  se_plus1;
	logic [13:0] prod_a;
	logic [13:0] prod_b;

	always_comb begin
		se_plus1 = {1'b0, st_r.se} + 6'h01;
		prod_a   = {6'h00, coil_a_i} * {8'h00, se_plus1};
		prod_b   = {6'h00, coil_b_i} * {8'h00, se_plus1};
	end

	// candidate factor after one regulation event
	logic [6:0] se_up;
	logic [5:0] se_work;
	logic [5:0] dn_next;

	assign dn_next = st_r.dn_cnt + 6'h01;

	always_comb begin
		st_nxt         = st_r;
		st_nxt.cmd_stb = 1'b0;
		st_nxt.sck_q   = sck_s;
		st_nxt.csn_q   = csn_s;
		se_up          = 7'h00;
		se_work        = {1'b0, st_r.se};

		// bus clock only counts while selected
		if (!csn_s) begin
			if (sck_rise) begin
				// first bit ends up at the top
				st_nxt.shift = {st_r.shift[`LACS_CMD_MSB-1:0], sdi_s};
			end
			if (sck_fall) begin
				st_nxt.sdo = st_r.shift[`LACS_CMD_MSB];
			end
		end

		if (csn_rise) begin
			st_nxt.cmd     = st_r.shift;
			st_nxt.cmd_stb = 1'b1;
		end

		// regulation on each delivered measurement; the decrement counter
		// survives the middle band so slow unloading still lowers the current
		if (filt_valid) begin
			if (filt_load < thr_lo) begin
				se_up          = {2'h0, st_r.se} + {1'b0, up_step};
				// a large step stops at the ceiling
				if (se_up > {2'h0, se_max}) begin
					se_work = {1'b0, se_max};
				end else begin
					se_work = se_up[5:0];
				end
				st_nxt.dn_cnt  = `LACS_DN_CNT_RST;
			end else if (filt_load >= thr_hi) begin
				if (dn_next >= dn_need) begin
					st_nxt.dn_cnt = `LACS_DN_CNT_RST;
					if (st_r.se > se_min) begin
						se_work = {1'b0, st_r.se} - 6'h01;
					end else begin
						se_work = {1'b0, se_min};
					end
				end else begin
					st_nxt.dn_cnt = dn_next;
				end
			end
		end

		// keep status inside the limits, also when the scale moves
		if (se_work > {1'b0, se_max}) begin
			st_nxt.se = se_max;
		end else if (se_work < {1'b0, se_min}) begin
			st_nxt.se = se_min;
		end else begin
			st_nxt.se = se_work[4:0];
		end

		st_nxt.coil_a = prod_a[12:`LACS_SCALE_SHIFT];
		st_nxt.coil_b = prod_b[12:`LACS_SCALE_SHIFT];
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_r <= '{
				sck_q:   1'b1,
				csn_q:   1'b1,
				shift:   `LACS_SHIFT_RST,
				sdo:     1'b0,
				cmd:     `LACS_CMD_RST,
				cmd_stb: 1'b0,
				se:      `LACS_SE_RST,
				dn_cnt:  `LACS_DN_CNT_RST,
				coil_a:  8'h00,
				coil_b:  8'h00
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sdo_o                    = st_r.sdo;
	assign cmd_word_o               = st_r.cmd;
	assign cmd_stb_o                = st_r.cmd_stb;
	assign coil_a_scaled_o          = st_r.coil_a;
	assign coil_b_scaled_o          = st_r.coil_b;
	assign applied_current_factor_o = st_r.se;

endmodule : lacs_top

// ==== tb/lacs_host_model.sv ====
/*
 * Serial bus master model: mode 3, 125 ns bus clock, msb first.
 * Assumes the caller passes at least 20 bits per selected frame.
 */
`timescale 1ns/1ps

module lacs_host_model (
	output logic        sck_o,
	output logic        sdi_o,
	output logic        cs_n_o,
	input  wire logic   sdo_i
);
	logic [63:0] rx;

	initial begin
		sck_o = 1'b1;
		sdi_o = 1'b0;
		cs_n_o = 1'b1;
		rx = '0;
	end

	task automatic xfer(input logic [63:0] w, input int n, input logic sel);
		cs_n_o = !sel;
		#101;
		for (int i = n - 1; i >= 0; i--) begin
			sck_o = 1'b0;
			sdi_o = w[i];
			#62.5;
			sck_o = 1'b1;
			rx = {rx[62:0], sdo_i};
			#62.5;
		end
		#101;
		cs_n_o = 1'b1;
		// undriven data must not look like the last bit
		sdi_o = !sdi_o;
		#101;
	endtask : xfer
endmodule : lacs_host_model

// ==== tb/lacs_top_asserts.sv ====
/*
 * Port-level assertions for lacs_top, bound into every instance.
 * Assumes a single clk_i domain with rst_n_i as asynchronous reset.
 */
`timescale 1ns/1ps

module lacs_top_asserts
	import lacs_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       csn_i,
	input  wire logic       sdo_o,
	input  wire logic [19:0] cmd_word_o,
	input  wire logic       cmd_stb_o,
	input  wire lacs_cfg_t  cfg_i,
	input  wire logic [9:0] load_measurement_i,
	input  wire logic       load_valid_i,
	input  wire logic [7:0] coil_a_i,
	input  wire logic [7:0] coil_a_scaled_o,
	input  wire logic [4:0] applied_current_factor_o
);
	logic [4:0]  cs, f, mn, up, dn;
	logic [5:0]  fr, us;
	logic [9:0]  lo, hi, m;
	logic [13:0] pa;
	logic        ok;

	assign cs = cfg_i.current_scale;
	assign f  = applied_current_factor_o;
	assign m  = load_measurement_i;
	assign ok = load_valid_i && !cfg_i.load_filter_enable;
	assign fr = ({1'b0, cs} + 6'h01) >> (cfg_i.minimum_current_limit_bit ? 2 : 1);
	assign mn = (fr == 6'h00) ? 5'h00 : 5'(fr - 6'h01);
	assign us = {1'b0, f} + (6'h01 << cfg_i.increment_step_code);
	assign up = (us > {1'b0, cs}) ? cs : us[4:0];
	assign dn = (f > mn) ? f - 5'h01 : f;
	assign lo = {1'b0, cfg_i.lower_load_threshold_code, 5'h00};
	assign hi = 10'(({6'h00, cfg_i.lower_load_threshold_code}
		+ cfg_i.upper_load_window_code + 10'h001) << 5);
	assign pa = coil_a_i * ({1'b0, f} + 6'h01);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// result lands two edges after the pulse
	sequence low_seen;
		ok && m < lo ##1 1'b1;
	endsequence
	sequence high_seen;
		ok && m >= hi && cfg_i.decrement_rate_code == 2'h3 ##1 1'b1;
	endsequence
	sequence mid_seen;
		ok && m >= lo && m < hi ##1 1'b1;
	endsequence

	factor_max_a: assert property ($stable(cfg_i) && $past(rst_n_i) |-> f <= cs)
		else $error("factor above scale");
	factor_min_a: assert property ($stable(cfg_i) && $past(rst_n_i) |-> f >= mn)
		else $error("factor below floor");
	step_up_a: assert property (low_seen |=> f == $past(up))
		else $error("wrong increment");
	step_down_a: assert property (high_seen |=> f == $past(dn))
		else $error("wrong decrement");
	mid_hold_a: assert property (mid_seen |=> $stable(f))
		else $error("factor moved in band");
	coil_scale_a: assert property (1'b1 |=> coil_a_scaled_o == $past(pa[12:5]))
		else $error("coil scaling wrong");
	stb_single_a: assert property (cmd_stb_o |=> !cmd_stb_o)
		else $error("strobe too long");
	cmd_hold_a: assert property ($changed(cmd_word_o) |-> cmd_stb_o)
		else $error("command changed alone");
	stb_after_sel_a: assert property (cmd_stb_o |-> csn_i && $past(csn_i, 3))
		else $error("strobe without select rise");
	sdo_quiet_a: assert property (csn_i [*8] |=> $stable(sdo_o))
		else $error("output moved unselected");
endmodule : lacs_top_asserts

bind lacs_top lacs_top_asserts lacs_top_asserts_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .csn_i(csn_i), .sdo_o(sdo_o),
	.cmd_word_o(cmd_word_o), .cmd_stb_o(cmd_stb_o), .cfg_i(cfg_i),
	.load_measurement_i(load_measurement_i), .load_valid_i(load_valid_i),
	.coil_a_i(coil_a_i), .coil_a_scaled_o(coil_a_scaled_o),
	.applied_current_factor_o(applied_current_factor_o)
);

// ==== tb/tb.sv ====
/*
 * Self-checking bench for lacs_top: regulator steps, limits, filter, serial port.
 * Assumes lacs_host_model drives the serial pins and the checker is bound.
 */
`timescale 1ns/1ps

module tb;
	import lacs_pkg::*;

	logic       clk_i, rst_n_i, sck, sdi, cs_n, sdo, stb, lv;
	logic [19:0] cmd;
	lacs_cfg_t  cfg;
	logic [9:0] meas;
	logic [7:0] ca, cb, sa, sb;
	logic [4:0] fac;
	int         mismatches, n_compared, nstb, e;
	int         need[4] = '{32, 8, 2, 1};

`define CHK(n, x, s) begin n_compared++; if ((s) !== (x)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", n, x, s); end end

	lacs_top lacs_top_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .sdi_i(sdi), .csn_i(cs_n),
		.sdo_o(sdo), .cmd_word_o(cmd), .cmd_stb_o(stb), .cfg_i(cfg),
		.load_measurement_i(meas), .load_valid_i(lv), .coil_a_i(ca), .coil_b_i(cb),
		.coil_a_scaled_o(sa), .coil_b_scaled_o(sb), .applied_current_factor_o(fac)
	);
	lacs_host_model lacs_host_model_inst (
		.sck_o(sck), .sdi_o(sdi), .cs_n_o(cs_n), .sdo_i(sdo)
	);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (stb === 1'b1) nstb++;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	task automatic load(input logic [9:0] v);
		@(posedge clk_i);
		meas <= v;
		lv <= 1'b1;
		@(posedge clk_i);
		lv <= 1'b0;
		tick(3);
	endtask : load

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		#100000;
		mismatches++;
		finish_test();
	end

	initial begin
		rst_n_i = 1'b0;
		lv = 1'b0;
		meas = '0;
		ca = '0;
		cb = '0;
		cfg = {5'h14, 2'h0, 2'h0, 1'b0, 4'h2, 4'h3, 1'b0};
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		tick(8);
		`CHK("factor", 5'h14, fac)
		@(posedge clk_i);
		ca <= 8'hc8;
		cb <= 8'h64;
		tick(2);
		`CHK("coil_a", 8'h83, sa)
		`CHK("coil_b", 8'h41, sb)
		for (int c = 0; c < 4; c++) begin
			@(posedge clk_i);
			cfg.decrement_rate_code <= 2'(c);
			repeat (need[c] - 1) load(10'h0c0);
			`CHK("hold", 5'h14 - 5'(c), fac)
			load(10'h0c0);
			`CHK("dec", 5'h13 - 5'(c), fac)
		end
		load(10'h040);
		load(10'h0bf);
		`CHK("band", 5'h10, fac)
		repeat (8) load(10'h3ff);
		`CHK("floor", 5'h09, fac)
		e = 9;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk_i);
			cfg.increment_step_code <= 2'(c);
			load(10'h03f);
			e = (e + (1 << c) > 20) ? 20 : e + (1 << c);
			`CHK("inc", 5'(e), fac)
		end
		@(posedge clk_i);
		cfg.minimum_current_limit_bit <= 1'b1;
		repeat (20) load(10'h3ff);
		`CHK("floor4", 5'h04, fac)
		$display("test regulator done");
		@(posedge clk_i);
		cfg.load_filter_enable <= 1'b1;
		cfg.increment_step_code <= 2'h0;
		for (int i = 0; i < 8; i++) begin
			load((i % 4 == 3) ? 10'h0ff + 10'(i / 4) : 10'h000);
			`CHK("filt", 5'h04 + 5'(i >= 3), fac)
		end
		$display("test filter done");
		lacs_host_model_inst.xfer(64'habcde, 20, 1'b1);
		tick(10);
		`CHK("cmd", 20'habcde, cmd)
		`CHK("stb", 1, nstb)
		lacs_host_model_inst.xfer(64'h12345, 20, 1'b0);
		tick(10);
		`CHK("ignored", 20'habcde, cmd)
		`CHK("no_stb", 1, nstb)
		lacs_host_model_inst.xfer({24'h0, 20'h13579, 20'h2468a}, 40, 1'b1);
		tick(10);
		`CHK("last20", 20'h2468a, cmd)
		`CHK("chain", {20'habcde, 20'h13579}, lacs_host_model_inst.rx[39:0])
		$display("test serial done");
		finish_test();
	end
endmodule : tb
